/* File: common/mps_params.svh */
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH

// Register indices on the plain register port
`define MPS_ADDR_PWM        4'h0
`define MPS_ADDR_CFG        4'h1
`define MPS_ADDR_ISTAT      4'h2
`define MPS_ADDR_IMASK      4'h3

// Reset values
`define MPS_PWM_RESET       8'h00
`define MPS_CFG_RESET       8'h02
`define MPS_IMASK_RESET     2'h0
`define MPS_ISTAT_RESET     2'h0

// pwm_gate_offtime fields
`define MPS_PWM_DEBUG_BIT   7
`define MPS_PWM_GATE_HI     6
`define MPS_PWM_GATE_LO     4
`define MPS_PWM_OFF_HI      3
`define MPS_PWM_OFF_LO      0

// sampling_clock_config fields
`define MPS_CFG_DELAY_HI    7
`define MPS_CFG_DELAY_LO    4
`define MPS_CFG_FLAG_BIT    3
`define MPS_CFG_MASK_BIT    2
`define MPS_CFG_PRE_HI      1
`define MPS_CFG_PRE_LO      0

// Interrupt status and mask layout
`define MPS_IRQ_LATE_BIT    0
`define MPS_IRQ_COMM_BIT    1
`define MPS_IRQ_ZERO_BIT    2

// Prescaler selections and terminal counts
`define MPS_PRE_DIV1        2'h0
`define MPS_PRE_DIV2        2'h1
`define MPS_PRE_LAST_DIV1   2'h0
`define MPS_PRE_LAST_DIV2   2'h1
`define MPS_PRE_LAST_DIV4   2'h3

// Timing: one code step is 2.5 us at a 4 MHz peripheral clock
`define MPS_STEP_NS         2500
`define MPS_PERIPH_REF_KHZ  4000
`define MPS_NS_PER_MS       1000000
`define MPS_STEP_TICKS      ((`MPS_STEP_NS * `MPS_PERIPH_REF_KHZ) / `MPS_NS_PER_MS)

`endif

/* File: common/mps_pkg.sv */
package mps_pkg;

   typedef enum logic [0:0] {
      MPS_SMP_IDLE,
      MPS_SMP_WAIT
   } mps_smp_state_type;

   typedef logic [7:0] mps_reg_type;
   typedef logic [1:0] mps_pre_type;

endpackage

/* File: core/mps_prescaler.sv */
`timescale 1ns/1ps
`include "mps_params.svh"

module mps_prescaler (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire mps_pkg::mps_pre_type div_sel,
   output logic                  tick
);
   import mps_pkg::*;

   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic       tick_ff;
   logic [1:0] last_cnt;
   logic       at_last;

   // ************************************************
   // Divide selection: 10 and 11 both divide by four
   // ************************************************
   assign last_cnt = (div_sel == `MPS_PRE_DIV1) ? `MPS_PRE_LAST_DIV1 :
                     (div_sel == `MPS_PRE_DIV2) ? `MPS_PRE_LAST_DIV2 :
                                                  `MPS_PRE_LAST_DIV4;
   assign at_last  = (cnt_ff >= last_cnt);
   assign nxt_cnt  = at_last ? 2'h0 : cnt_ff + 2'h1;
   assign tick     = tick_ff;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_ff  <= 2'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= at_last;
      end
   end

   // A tick always leaves the count at zero, so at divide by four three quiet cycles must follow it
   a_div4_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tick_ff && div_sel[1]) ##1 div_sel[1] [*2] |=>
         !tick_ff && !$past(tick_ff) && !$past(tick_ff, 2))
      else $error("divide-by-four tick came early");

   a_div1_every: assert property (@(posedge sys_clk) disable iff (!nrst)
      (div_sel == `MPS_PRE_DIV1) [*2] |=> tick_ff)
      else $error("undivided tick missing");

endmodule // mps_prescaler

/* File: core/mps_top.sv */
`timescale 1ns/1ps
`include "mps_params.svh"

// Functional notes
// - Debug bit routes C/D/Z events, or C/U in speed mode, to debug pins
// - Each W/V/U gate bit passes its compare PWM to its pin
// - Sensorless, zero delay code, on_time_sampling low: minimum off-time 2.5 us times (code+1)
// - All durations are counted in peripheral clock ticks, 4 MHz reference
// - Delay code sets on-time sampling wait 2.5 us times code; zero means off-time
// - Sample expiring in off-time is discarded and sets the late flag
// - Late mask bit enables the late-sample interrupt
// - Late-sample interrupt concerns zero-crossing sampling only
// - Late-sample interrupt only possible with a nonzero delay code
// - Prescaler: 00 undivided, 01 divide by 2, 1x divide by 4
// - Reset loads config register 02h and PWM register 00h
module mps_top (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic [3:0]        reg_addr,
   input  wire mps_pkg::mps_reg_type reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output mps_pkg::mps_reg_type   reg_rdata,
   input  wire logic              cmp_pwm_u,
   input  wire logic              cmp_pwm_v,
   input  wire logic              cmp_pwm_w,
   input  wire logic              pwm_on_time,
   input  wire logic              sensor_select,
   input  wire logic              speed_mode,
   input  wire logic              on_time_sampling,
   input  wire logic              comm_event,
   input  wire logic              demag_event,
   input  wire logic              zero_event,
   input  wire logic              u_event,
   output logic                   u_phase_pwm_pin,
   output logic                   v_phase_pwm_pin,
   output logic                   w_phase_pwm_pin,
   output logic                   debug_cd_event_pin,
   output logic                   debug_zero_event_pin,
   output logic                   zero_sample_strobe,
   output logic                   peripheral_clock,
   output logic                   irq
);
   import mps_pkg::*;

   localparam logic [7:0] STEP_TICKS = 8'(`MPS_STEP_TICKS);

   // ************************************************
   // Registers
   // ************************************************
   mps_reg_type       pwm_reg_ff;
   mps_reg_type       cfg_reg_ff;
   logic [2:1]        istat_ff;
   logic [2:1]        imask_ff;
   mps_reg_type       rdata_ff;
   logic              irq_ff;
   logic [1:0]        dbg_ff;
   logic              strobe_ff;
   logic              pwm_on_d_ff;
   mps_smp_state_type smp_state_ff;
   logic [7:0]        dly_cnt_ff;
   logic [2:0]        out_ff;
   logic [7:0]        off_cnt_ff [3];

   mps_reg_type       nxt_pwm_reg;
   mps_reg_type       nxt_cfg_reg;
   logic [2:1]        nxt_istat;
   logic [2:1]        nxt_imask;
   mps_reg_type       nxt_rdata;
   logic              nxt_irq;
   logic [1:0]        nxt_dbg;
   logic              nxt_strobe;
   logic              nxt_flag;
   mps_smp_state_type nxt_smp_state;
   logic [7:0]        nxt_dly_cnt;
   logic [2:0]        nxt_out;
   logic [7:0]        nxt_off_cnt [3];

   // ************************************************
   // Address decode and field views
   // ************************************************
   wire       wr_pwm    = reg_wr && (reg_addr == `MPS_ADDR_PWM);
   wire       wr_cfg    = reg_wr && (reg_addr == `MPS_ADDR_CFG);
   wire       wr_istat  = reg_wr && (reg_addr == `MPS_ADDR_ISTAT);
   wire       wr_imask  = reg_wr && (reg_addr == `MPS_ADDR_IMASK);
   wire       dbg_on    = pwm_reg_ff[`MPS_PWM_DEBUG_BIT];
   wire [2:0] gate      = pwm_reg_ff[`MPS_PWM_GATE_HI:`MPS_PWM_GATE_LO];
   wire [3:0] off_code  = pwm_reg_ff[`MPS_PWM_OFF_HI:`MPS_PWM_OFF_LO];
   wire [3:0] dly_code  = cfg_reg_ff[`MPS_CFG_DELAY_HI:`MPS_CFG_DELAY_LO];
   wire       late_flag = cfg_reg_ff[`MPS_CFG_FLAG_BIT];
   wire       late_mask = cfg_reg_ff[`MPS_CFG_MASK_BIT];
   wire [2:0] raw_pwm   = {cmp_pwm_w, cmp_pwm_v, cmp_pwm_u};
   wire       tick;

   // ************************************************
   // Peripheral clock prescaler
   // ************************************************
   mps_prescaler u_prescaler (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .div_sel (cfg_reg_ff[`MPS_CFG_PRE_HI:`MPS_CFG_PRE_LO]),
      .tick    (tick)
   );
   assign peripheral_clock = tick;

   // ************************************************
   // On-time sampling delay
   // ************************************************
   // Durations count prescaled ticks, so they scale with the prescaler
   wire [7:0] dly_target = 8'({4'h0, dly_code} * STEP_TICKS);
   wire       pwm_on_rise = pwm_on_time && !pwm_on_d_ff;
   // Only zero-crossing sampling in sensorless mode uses the delayed path
   wire       smp_start = pwm_on_rise && (dly_code != 4'h0) && !sensor_select;
   wire       smp_expire = (smp_state_ff == MPS_SMP_WAIT) && tick &&
                           (dly_cnt_ff >= dly_target - 8'h01);
   wire       late_set  = smp_expire && !pwm_on_time;

   always_comb begin
      nxt_smp_state = smp_state_ff;
      nxt_dly_cnt   = dly_cnt_ff;
      nxt_strobe    = 1'b0;
      case (smp_state_ff)
         MPS_SMP_IDLE: begin
            if (smp_start) begin
               nxt_smp_state = MPS_SMP_WAIT;
               nxt_dly_cnt   = 8'h00;
            end
         end
         MPS_SMP_WAIT: begin
            if (smp_expire) begin
               nxt_smp_state = MPS_SMP_IDLE;
               nxt_strobe    = pwm_on_time;
            end else if (tick) begin
               nxt_dly_cnt = dly_cnt_ff + 8'h01;
            end
         end
         default: begin
            nxt_smp_state = MPS_SMP_IDLE;
         end
      endcase
   end

   // ************************************************
   // Minimum off-time, one stage per phase
   // ************************************************
   wire       enforce    = !sensor_select && (dly_code == 4'h0) && !on_time_sampling;
   wire [7:0] off_target = 8'(({4'h0, off_code} + 8'h01) * STEP_TICKS);

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase
         wire off_ok = !enforce || (off_cnt_ff[gi] >= off_target);
         // Once on, a pulse is not cut short; only its restart is held back
         assign nxt_out[gi] = gate[gi] && raw_pwm[gi] && (out_ff[gi] || off_ok);
         assign nxt_off_cnt[gi] = out_ff[gi] ? 8'h00 :
                                  (tick && off_cnt_ff[gi] != 8'hff) ?
                                  off_cnt_ff[gi] + 8'h01 : off_cnt_ff[gi];

         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               out_ff[gi]     <= 1'b0;
               off_cnt_ff[gi] <= 8'hff;
            end else begin
               out_ff[gi]     <= nxt_out[gi];
               off_cnt_ff[gi] <= nxt_off_cnt[gi];
            end
         end

         a_gate_blocks: assert property (@(posedge sys_clk) disable iff (!nrst)
            !gate[gi] |=> !out_ff[gi])
            else $error("phase pin driven with gate clear");

         a_min_off_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
            (enforce && !out_ff[gi] && off_cnt_ff[gi] < off_target) |=> !out_ff[gi])
            else $error("phase restarted inside minimum off-time");
      end
   endgenerate

   assign u_phase_pwm_pin = out_ff[0];
   assign v_phase_pwm_pin = out_ff[1];
   assign w_phase_pwm_pin = out_ff[2];

   // ************************************************
   // Debug event pins
   // ************************************************
   assign nxt_dbg[0] = dbg_on && (speed_mode ? comm_event : (comm_event || demag_event));
   assign nxt_dbg[1] = dbg_on && (speed_mode ? u_event : zero_event);

   // ************************************************
   // Register updates and interrupt
   // ************************************************
   // Hardware set wins over a clear in the same cycle
   assign nxt_flag = late_set ||
                     (late_flag && !(wr_cfg && !reg_wdata[`MPS_CFG_FLAG_BIT]) &&
                      !(wr_istat && reg_wdata[`MPS_IRQ_LATE_BIT]));

   always_comb begin
      nxt_pwm_reg = wr_pwm ? reg_wdata : pwm_reg_ff;
      nxt_cfg_reg = wr_cfg ? reg_wdata : cfg_reg_ff;
      nxt_cfg_reg[`MPS_CFG_FLAG_BIT] = nxt_flag;
      if (wr_imask) begin
         nxt_cfg_reg[`MPS_CFG_MASK_BIT] = reg_wdata[`MPS_IRQ_LATE_BIT];
      end
      nxt_imask = wr_imask ? reg_wdata[2:1] : imask_ff;
      nxt_istat = istat_ff & ~(wr_istat ? reg_wdata[2:1] : 2'h0);
      nxt_istat = nxt_istat | {zero_event, comm_event};
   end

   assign nxt_irq = (late_flag && late_mask) || |(istat_ff & imask_ff);

   assign nxt_rdata = !reg_rd                     ? 8'h00 :
                      (reg_addr == `MPS_ADDR_PWM)   ? pwm_reg_ff :
                      (reg_addr == `MPS_ADDR_CFG)   ? cfg_reg_ff :
                      (reg_addr == `MPS_ADDR_ISTAT) ? {5'h00, istat_ff, late_flag} :
                      (reg_addr == `MPS_ADDR_IMASK) ? {5'h00, imask_ff, late_mask} :
                                                      8'h00;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pwm_reg_ff   <= `MPS_PWM_RESET;
         cfg_reg_ff   <= `MPS_CFG_RESET;
         istat_ff     <= `MPS_ISTAT_RESET;
         imask_ff     <= `MPS_IMASK_RESET;
         rdata_ff     <= 8'h00;
         irq_ff       <= 1'b0;
         dbg_ff       <= 2'h0;
         strobe_ff    <= 1'b0;
         pwm_on_d_ff  <= 1'b0;
         smp_state_ff <= MPS_SMP_IDLE;
         dly_cnt_ff   <= 8'h00;
      end else begin
         pwm_reg_ff   <= nxt_pwm_reg;
         cfg_reg_ff   <= nxt_cfg_reg;
         istat_ff     <= nxt_istat;
         imask_ff     <= nxt_imask;
         rdata_ff     <= nxt_rdata;
         irq_ff       <= nxt_irq;
         dbg_ff       <= nxt_dbg;
         strobe_ff    <= nxt_strobe;
         pwm_on_d_ff  <= pwm_on_time;
         smp_state_ff <= nxt_smp_state;
         dly_cnt_ff   <= nxt_dly_cnt;
      end
   end

   assign reg_rdata            = rdata_ff;
   assign irq                  = irq_ff;
   assign debug_cd_event_pin   = dbg_ff[0];
   assign debug_zero_event_pin = dbg_ff[1];
   assign zero_sample_strobe   = strobe_ff;

   // ************************************************
   // Checks
   // ************************************************
   a_reset_values: assert property (@(posedge sys_clk)
      !nrst |=> (cfg_reg_ff == `MPS_CFG_RESET) && (pwm_reg_ff == `MPS_PWM_RESET))
      else $error("register reset values wrong");

   a_debug_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      !dbg_on |=> !debug_cd_event_pin && !debug_zero_event_pin)
      else $error("debug pin active outside debug mode");

   a_debug_speed: assert property (@(posedge sys_clk) disable iff (!nrst)
      (dbg_on && speed_mode && u_event) |=> debug_zero_event_pin)
      else $error("U event missing on debug pin");

   a_late_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      late_set |=> late_flag && !zero_sample_strobe)
      else $error("late sample not flagged or not discarded");

   a_late_delay: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(late_flag) |-> $past(dly_code) != 4'h0)
      else $error("late flag with zero delay code");

   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
      (late_flag && !wr_cfg && !wr_istat) |=> late_flag)
      else $error("late flag dropped without a write");

   a_irq_raise: assert property (@(posedge sys_clk) disable iff (!nrst)
      (late_flag && late_mask) |=> irq)
      else $error("interrupt missing for masked-in late flag");

   a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!(late_flag && late_mask) && !(|(istat_ff & imask_ff))) |=> !irq)
      else $error("interrupt without enabled source");

   a_delay_start: assert property (@(posedge sys_clk) disable iff (!nrst)
      (smp_start && smp_state_ff == MPS_SMP_IDLE) |=> smp_state_ff == MPS_SMP_WAIT
         ##1 (smp_state_ff == MPS_SMP_WAIT) [*8])
      else $error("sampling delay did not run");

endmodule // mps_top

/* File: verif/mps_stage_model.sv */
`timescale 1ns/1ps

// ****************************************
// Power stage view of the U phase switch
// ****************************************
module mps_stage_model (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        u_phase_pwm_pin,
   output logic [15:0]      u_low_run
);
   logic [15:0] run_ff;

   // The stage only learns an off-time once the switch is driven on again
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         run_ff    <= 16'h0000;
         u_low_run <= 16'h0000;
      end else if (u_phase_pwm_pin) begin
         if (run_ff != 16'h0000) begin
            u_low_run <= run_ff;
         end
         run_ff <= 16'h0000;
      end else begin
         run_ff <= run_ff + 16'h0001;
      end
   end
endmodule // mps_stage_model

/* File: verif/motor_pwm_offtime_sampling_config_tb_top.sv */
`timescale 1ns/1ps
`include "mps_params.svh"

module motor_pwm_offtime_sampling_config_tb_top;
   import mps_pkg::*;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   mps_reg_type reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   mps_reg_type reg_rdata;
   logic [2:0]  raw = 3'b000;
   logic        on_t = 1'b0;
   logic        sens = 1'b0;
   logic        ots = 1'b0;
   logic        spd = 1'b0;
   logic [3:0]  ev = 4'h0;
   logic        pu, pv, pw, dcd, dz, strobe, ptick, irq;
   logic [15:0] u_low_run;
   logic        rd_taken = 1'b0;
   logic [7:0]  exp_q[$];
   int          n_errors = 0;
   int          samples_checked = 0;
   int          n_strobe = 0;
   int          n, s0, d, lo, hi;
   int          cs[6] = '{0, 1, 2, 15, 15, 15};
   int          ps[6] = '{0, 1, 3, 0, 0, 0};
   int          ks[3] = '{1, 2, 15};

   mps_top i_mps_top (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmp_pwm_u(raw[0]), .cmp_pwm_v(raw[1]), .cmp_pwm_w(raw[2]), .pwm_on_time(on_t),
      .sensor_select(sens), .speed_mode(spd), .on_time_sampling(ots),
      .comm_event(ev[0]), .demag_event(ev[1]), .zero_event(ev[2]), .u_event(ev[3]),
      .u_phase_pwm_pin(pu), .v_phase_pwm_pin(pv), .w_phase_pwm_pin(pw),
      .debug_cd_event_pin(dcd), .debug_zero_event_pin(dz), .zero_sample_strobe(strobe),
      .peripheral_clock(ptick), .irq(irq));

   mps_stage_model i_mps_stage_model (.sys_clk(sys_clk), .nrst(nrst),
      .u_phase_pwm_pin(pu), .u_low_run(u_low_run));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask

   // Counts falling edges until the chosen output is seen high
   task automatic wait_for(input int which, output int cnt);
      cnt = 0;
      do begin
         @(negedge sys_clk);
         cnt++;
      end while (!(which == 0 ? pu : which == 1 ? strobe : ptick) && cnt < 400);
      if (cnt >= 400) begin
         check("wait bound", 16'h0000, 16'h0001);
         give_verdict();
      end
   endtask

   function automatic int divof(input int p);
      return (p == 0) ? 1 : (p == 1) ? 2 : 4;
   endfunction

   // ****************************************
   // Read data watcher and strobe counter
   // ****************************************
   always @(posedge sys_clk) begin
      rd_taken <= reg_rd;
      if (strobe === 1'b1) n_strobe++;
   end

   always @(negedge sys_clk) begin
      if (rd_taken) check("reg_rdata", reg_rdata, exp_q.pop_front());
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h683c82e4));
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`MPS_ADDR_PWM, 8'h00);
      rd(`MPS_ADDR_CFG, 8'h02);
      rd(4'hF, 8'h00);
      repeat (4) begin
         d = $urandom;
         wr(`MPS_ADDR_PWM, d[7:0]);
         rd(`MPS_ADDR_PWM, d[7:0]);
         wr(`MPS_ADDR_CFG, d[15:8]);
         rd(`MPS_ADDR_CFG, d[15:8] & 8'hF7);
      end
      for (int p = 0; p < 4; p++) begin
         wr(`MPS_ADDR_CFG, {6'h00, p[1:0]});
         repeat (6) @(negedge sys_clk);
         wait_for(2, n);
         wait_for(2, n);
         check("tick period", 16'(n), 16'(divof(p)));
      end
      for (int i = 0; i < 6; i++) begin
         sens <= (i == 4);
         ots <= (i == 5);
         wr(`MPS_ADDR_PWM, 8'h10 | 8'(cs[i]));
         wr(`MPS_ADDR_CFG, 8'(ps[i]));
         raw <= 3'b001;
         wait_for(0, n);
         @(posedge sys_clk);
         raw <= 3'b000;
         repeat (2) @(posedge sys_clk);
         raw <= 3'b001;
         wait_for(0, n);
         @(negedge sys_clk);
         d = (cs[i] + 1) * 10 * divof(ps[i]);
         lo = (i >= 4) ? 1 : d - divof(ps[i]);
         hi = (i >= 4) ? 3 : d + divof(ps[i]) + 3;
         check("u low run", 16'(u_low_run >= lo && u_low_run <= hi), 16'h0001);
      end
      sens <= 1'b1;
      ots <= 1'b0;
      for (int g = 0; g < 8; g++) begin
         wr(`MPS_ADDR_PWM, {1'b0, g[2:0], 4'h0});
         raw <= 3'($urandom);
         repeat (3) @(posedge sys_clk);
         @(negedge sys_clk);
         check("pwm pins", 16'({pw, pv, pu}), 16'(g[2:0] & raw));
      end
      sens <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wr(`MPS_ADDR_CFG, {ks[i][3:0], 2'b00, i[0] ? 2'b01 : 2'b00});
         @(posedge sys_clk);
         on_t <= 1'b1;
         wait_for(1, n);
         d = ks[i] * 10 * (i[0] ? 2 : 1);
         check("strobe delay", 16'(n >= d - 2 && n <= d + 5), 16'h0001);
         @(posedge sys_clk);
         on_t <= 1'b0;
      end
      wr(`MPS_ADDR_CFG, 8'h10);
      wr(`MPS_ADDR_CFG, 8'h14);
      s0 = n_strobe;
      @(posedge sys_clk);
      on_t <= 1'b1;
      repeat (3) @(posedge sys_clk);
      on_t <= 1'b0;
      repeat (20) @(negedge sys_clk);
      check("late strobes", 16'(n_strobe - s0), 16'h0000);
      check("irq", irq, 1'b1);
      rd(`MPS_ADDR_CFG, 8'h1C);
      wr(`MPS_ADDR_CFG, 8'h1C);
      rd(`MPS_ADDR_CFG, 8'h1C);
      rd(`MPS_ADDR_ISTAT, 8'h01);
      wr(`MPS_ADDR_CFG, 8'h18);
      repeat (3) @(negedge sys_clk);
      check("irq", irq, 1'b0);
      wr(`MPS_ADDR_IMASK, 8'h01);
      repeat (3) @(negedge sys_clk);
      check("irq", irq, 1'b1);
      wr(`MPS_ADDR_CFG, 8'h14);
      repeat (3) @(negedge sys_clk);
      check("irq", irq, 1'b0);
      // Sensor mode must not start the delayed zero-crossing sample
      @(posedge sys_clk);
      sens <= 1'b1;
      on_t <= 1'b1;
      repeat (3) @(posedge sys_clk);
      on_t <= 1'b0;
      repeat (20) @(negedge sys_clk);
      check("irq", irq, 1'b0);
      rd(`MPS_ADDR_CFG, 8'h14);
      wr(`MPS_ADDR_CFG, 8'h04);
      sens <= 1'b0;
      @(posedge sys_clk);
      on_t <= 1'b1;
      repeat (3) @(posedge sys_clk);
      on_t <= 1'b0;
      repeat (20) @(negedge sys_clk);
      check("irq", irq, 1'b0);
      rd(`MPS_ADDR_CFG, 8'h04);
      for (int i = 0; i < 16; i++) begin
         wr(`MPS_ADDR_PWM, {i[3], 7'h00});
         spd <= i[2];
         @(posedge sys_clk);
         ev <= 4'h1 << i[1:0];
         @(posedge sys_clk);
         ev <= 4'h0;
         @(negedge sys_clk);
         check("debug cd pin", dcd, i[3] & (i[2] ? i[1:0] == 0 : i[1:0] < 2));
         check("debug zero pin", dz, i[3] & (i[1:0] == (i[2] ? 3 : 2)));
      end
      rd(`MPS_ADDR_ISTAT, 8'h06);
      wr(`MPS_ADDR_IMASK, 8'h04);
      repeat (3) @(negedge sys_clk);
      check("irq", irq, 1'b1);
      wr(`MPS_ADDR_ISTAT, 8'h04);
      repeat (3) @(negedge sys_clk);
      check("irq", irq, 1'b0);
      rd(`MPS_ADDR_ISTAT, 8'h02);
      // Second reset in mid-run must bring written registers back
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`MPS_ADDR_PWM, 8'h00);
      rd(`MPS_ADDR_CFG, 8'h02);
      repeat (3) @(negedge sys_clk);
      give_verdict();
   end
endmodule // motor_pwm_offtime_sampling_config_tb_top
